// ===== hw/mpc_pkg.sv
package mpc_pkg;

	localparam int NUM_PINS = 5;

	// Register offsets, one per pin
	localparam logic [7:0] PIN1_CONTROL_OFS = 8'h74;
	localparam logic [7:0] PIN2_CONTROL_OFS = 8'h75;
	localparam logic [7:0] PIN3_CONTROL_OFS = 8'h76;
	localparam logic [7:0] PIN4_CONTROL_OFS = 8'h77;
	localparam logic [7:0] PIN5_CONTROL_OFS = 8'h78;

	// Field positions
	localparam int FN_LSB      = 8;
	localparam int FN_MSB      = 13;
	localparam int DIR_BIT     = 7;
	localparam int DRIVE_BIT   = 6;
	localparam int POL_BIT     = 5;
	localparam int LVL_BIT     = 4;
	localparam int PD_BIT      = 3;
	localparam int PU_BIT      = 2;
	localparam int INTMODE_BIT = 1;
	localparam int DB_BIT      = 0;

	// Function select encodings
	localparam logic [5:0] FN_GP_OUT    = 6'h00;
	localparam logic [5:0] FN_BIT_CLOCK = 6'h01;
	localparam logic [5:0] FN_IRQ_OUT   = 6'h02;
	localparam logic [5:0] FN_GP_IN     = 6'h03;
	localparam logic [5:0] FN_BIAS_CUR  = 6'h04;
	localparam logic [5:0] FN_BIAS_SHT  = 6'h05;
	localparam logic [5:0] FN_MIC       = 6'h06;

	// Reset values of control registers and write mask
	localparam logic [15:0] CTRL_RST_GP  = 16'h00a8;
	localparam logic [15:0] CTRL_RST_IRQ = 16'h02a8;
	localparam logic [15:0] CTRL_RST_BCK = 16'h01a8;
	localparam logic [15:0] CTRL_MASK    = 16'h3fff;

	// Debounce time and derived cycle count
	localparam int CLK_HZ       = 40_000_000;
	localparam int DEBOUNCE_US  = 100;
	localparam int DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
	localparam int DB_CNT_W     = 13;

	// Register bus request
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} mpc_bus_req_t;

	// One control register as fields
	typedef struct packed {
		logic [1:0] unused;
		logic [5:0] fn;
		logic       dir;
		logic       drive;
		logic       pol;
		logic       lvl;
		logic       pd;
		logic       pu;
		logic       intmode;
		logic       db;
	} mpc_ctrl_t;

	// Per-pin pad controls, four-signal form
	typedef struct packed {
		logic [NUM_PINS-1:0] out;
		logic [NUM_PINS-1:0] oe;
		logic [NUM_PINS-1:0] pu;
		logic [NUM_PINS-1:0] pd;
	} mpc_pad_t;

	// Internal function sources routed out to pins
	typedef struct packed {
		logic irq;
		logic bias_cur;
		logic bias_sht;
		logic mic_clk;
		logic bclk_out;
		logic bclk_oe;
	} mpc_src_t;

endpackage

// ===== hw/mpc_debounce.sv
`timescale 1ns/1ps
// Synchroniser plus debounce filter for one pin
module mpc_debounce (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	input  wire logic db_en_i,
	output logic      level_o
);
	import mpc_pkg::*;

	typedef struct packed {
		logic                meta;
		logic                sync;
		logic                stable;
		logic [DB_CNT_W-1:0] cnt;
	} mpc_db_state_t;

	mpc_db_state_t s_q;
	mpc_db_state_t s_d;

	localparam logic [DB_CNT_W-1:0] DB_LAST = DB_CNT_W'(DEBOUNCE_CYC - 1);

	// Counter restarts whenever sync matches stable; with db_en_i set a glitch shorter than DEBOUNCE_CYC never reaches status
	always_comb begin
		s_d      = s_q;
		s_d.meta = pin_i;
		s_d.sync = s_q.meta;
		if (!db_en_i) begin
			s_d.stable = s_q.sync;
			s_d.cnt    = '0;
		end else if (s_q.sync == s_q.stable) begin
			s_d.cnt = '0;
		end else if (s_q.cnt == DB_LAST) begin
			s_d.stable = s_q.sync;
			s_d.cnt    = '0;
		end else begin
			s_d.cnt = s_q.cnt + DB_CNT_W'(1);
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign level_o = s_q.stable;

endmodule

// ===== hw/mpc_top.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Multi-function pin control for five pins
module mpc_top (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  mpc_pkg::mpc_bus_req_t      bus_i,
	output logic [15:0]                rdata_o,
	input  wire logic [4:0]            pin_in_i,
	input  mpc_pkg::mpc_src_t          src_i,
	input  wire logic                  mclk_i,
	output mpc_pkg::mpc_pad_t          pad_o,
	output logic [4:0]                 pin_status_o,
	output logic [4:0]                 pin_irq_o,
	output logic                       mic_data_o,
	output logic                       bclk_in_o,
	output logic                       bclk_from_pin_o
);
	import mpc_pkg::*;

	// Whole module state
	typedef struct packed {
		logic [NUM_PINS-1:0][15:0] ctrl;
		logic [15:0]               rdata;
		logic [NUM_PINS-1:0]       status_prev;
		logic [NUM_PINS-1:0]       edge_evt;
		mpc_pad_t                  pad;
		logic                      mic_data;
		logic                      bclk_in;
	} mpc_state_t;

	mpc_state_t s_q;
	mpc_state_t s_d;

	logic [NUM_PINS-1:0] filt;
	logic [NUM_PINS-1:0] status;
	logic [NUM_PINS-1:0] sel;
	logic [NUM_PINS-1:0] sel_rd;
	logic                bclk_mode;

	// Reset values, pins 1-3 alike, pin 4 interrupt, pin 5 bit clock
	localparam logic [NUM_PINS-1:0][15:0] CTRL_RST = {
		CTRL_RST_BCK, CTRL_RST_IRQ, CTRL_RST_GP, CTRL_RST_GP, CTRL_RST_GP
	};

	// Synchroniser, debounce and polarity per pin
	for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
		mpc_ctrl_t c;
		assign c = mpc_ctrl_t'(s_q.ctrl[g]);
		mpc_debounce i_mpc_debounce (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.pin_i   (pin_in_i[g]),
			.db_en_i (c.db),
			.level_o (filt[g])
		);
		assign status[g] = c.pol ? filt[g] : ~filt[g];
		assign sel[g]    = bus_i.wr && (bus_i.addr == PIN1_CONTROL_OFS + 8'(g));
		assign sel_rd[g] = bus_i.rd && (bus_i.addr == PIN1_CONTROL_OFS + 8'(g));
	end

	assign bclk_mode = (s_q.ctrl[4][FN_MSB:FN_LSB] == FN_BIT_CLOCK);

	// Next state: registers, read data, pad drive and interrupt events
	always_comb begin
		mpc_ctrl_t c;
		logic      drv;
		logic      val;
		logic      out_en;
		c      = '0;
		drv    = 1'b0;
		val    = 1'b0;
		out_en = 1'b0;
		s_d    = s_q;

		// Register writes, two reserved top bits dropped
		for (int i = 0; i < NUM_PINS; i++) begin
			if (sel[i]) begin
				s_d.ctrl[i] = bus_i.wdata & CTRL_MASK;
			end
		end

		// Read answer, unmapped offsets read zero
		s_d.rdata = '0;
		for (int i = 0; i < NUM_PINS; i++) begin
			if (sel_rd[i]) begin
				s_d.rdata = s_q.ctrl[i];
			end
		end

		// Pad drive per pin, one cycle of output pipeline
		for (int i = 0; i < NUM_PINS; i++) begin
			c   = mpc_ctrl_t'(s_q.ctrl[i]);
			drv = 1'b0;
			val = 1'b0;
			unique case (c.fn)
				FN_GP_OUT: begin
					drv = 1'b1;
					val = c.lvl;
				end
				FN_IRQ_OUT: begin
					drv = 1'b1;
					val = src_i.irq;
				end
				FN_BIAS_CUR: begin
					drv = 1'b1;
					val = src_i.bias_cur;
				end
				FN_BIAS_SHT: begin
					drv = 1'b1;
					val = src_i.bias_sht;
				end
				FN_MIC: begin
					// Clock out only on pin one; pin two uses it as data in
					drv = (i == 0);
					val = src_i.mic_clk;
				end
				default: begin
					// Input and reserved codes leave the pad undriven
					drv = 1'b0;
					val = 1'b0;
				end
			endcase
			// Output stage only when the pin is an output
			out_en = drv && !c.dir;
			if (c.drive) begin
				// Open drain pulls low only
				s_d.pad.out[i] = 1'b0;
				s_d.pad.oe[i]  = out_en && !val;
			end else begin
				s_d.pad.out[i] = val;
				s_d.pad.oe[i]  = out_en;
			end
			s_d.pad.pu[i] = c.pu && !c.pd;
			s_d.pad.pd[i] = c.pd && !c.pu;
		end

		// Pin five pad drive in bit clock mode ignores every other field
		if (bclk_mode) begin
			s_d.pad.out[4] = src_i.bclk_out;
			s_d.pad.oe[4]  = src_i.bclk_oe;
			s_d.pad.pu[4]  = 1'b0;
			s_d.pad.pd[4]  = 1'b0;
		end

		// Mic data sampled only when pin two selects it
		s_d.mic_data = (s_q.ctrl[1][FN_MSB:FN_LSB] == FN_MIC) ? filt[1] : 1'b0;

		// Bit clock source: pin five or the master clock
		s_d.bclk_in = bclk_mode ? filt[4] : mclk_i;

		// Edge events on both transitions of status
		s_d.status_prev = status;
		s_d.edge_evt    = status ^ s_q.status_prev;
	end

	// State register with documented defaults
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q             <= '0;
			s_q.ctrl        <= CTRL_RST;
			s_q.status_prev <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Interrupt sources: level holds, edge is a one-cycle pulse
	for (genvar g = 0; g < NUM_PINS; g++) begin : g_irq
		assign pin_irq_o[g] = s_q.ctrl[g][INTMODE_BIT]
			? s_q.edge_evt[g]
			: status[g];
	end

	assign rdata_o         = s_q.rdata;
	assign pad_o           = s_q.pad;
	assign pin_status_o    = status;
	assign mic_data_o      = s_q.mic_data;
	assign bclk_in_o       = s_q.bclk_in;
	assign bclk_from_pin_o = bclk_mode;

endmodule

// ===== verif/mpc_properties.sv
`timescale 1ns/1ps
// Port-level checks of the pin control block
module mpc_properties (
	input wire logic          clk_i,
	input wire logic          rst_i,
	input mpc_pkg::mpc_bus_req_t bus_i,
	input wire logic [15:0]   rdata_o,
	input wire logic [4:0]    pin_in_i,
	input mpc_pkg::mpc_src_t  src_i,
	input wire logic          mclk_i,
	input mpc_pkg::mpc_pad_t  pad_o,
	input wire logic [4:0]    pin_status_o,
	input wire logic [4:0]    pin_irq_o,
	input wire logic          mic_data_o,
	input wire logic          bclk_in_o,
	input wire logic          bclk_from_pin_o
);
	import mpc_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Bus answers
	AST_UNMAPPED_READ: assert property (bus_i.rd && !(bus_i.addr inside {[8'h74:8'h78]}) |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	AST_TOP_BITS_ZERO: assert property ($past(bus_i.rd) |-> rdata_o[15:14] == 2'b00)
		else $error("bits 15:14 read back set");
	// Pin 1 output drive, write with no second write behind it
	AST_GP_OUT_LEVEL: assert property (bus_i.wr && bus_i.addr == 8'h74 && bus_i.wdata[13:6] == 8'h00 ##1 !bus_i.wr
		|=> pad_o.oe[0] && pad_o.out[0] == $past(bus_i.wdata[4], 2))
		else $error("general output level wrong");
	AST_OPEN_DRAIN: assert property (bus_i.wr && bus_i.addr == 8'h74 && bus_i.wdata[13:6] == 8'h01 ##1 !bus_i.wr
		|=> pad_o.oe[0] == !$past(bus_i.wdata[4], 2))
		else $error("open-drain drive wrong");
	AST_PULL_EXCLUSIVE: assert property ((pad_o.pu & pad_o.pd) == 5'h00)
		else $error("pull-up and pull-down together");
	// Status low with interrupt only just after a fall
	AST_EDGE_NEAR_CHANGE: assert property (pin_irq_o[1] && !pin_status_o[1]
		|-> $past(pin_status_o[1]) || $past(pin_status_o[1], 2))
		else $error("interrupt without status change");
	AST_BCLK_SELECT: assert property (bus_i.wr && bus_i.addr == 8'h78 ##1 !(bus_i.wr && bus_i.addr == 8'h78)
		|=> bclk_from_pin_o == ($past(bus_i.wdata[13:8], 2) == 6'h01))
		else $error("bit clock source select wrong");
	// Registered copy of master clock once the pin is not the source
	AST_MCLK_PATH: assert property (!bclk_from_pin_o && $past(!bclk_from_pin_o) |-> bclk_in_o == $past(mclk_i))
		else $error("master clock not passed");
	cover property (pin_irq_o[1] && !pin_status_o[1]);
	cover property ($fell(bclk_from_pin_o));
	cover property (pad_o.oe[0] && pad_o.out[0]);
endmodule
bind mpc_top mpc_properties i_mpc_properties (.clk_i, .rst_i, .bus_i, .rdata_o, .pin_in_i, .src_i, .mclk_i,
	.pad_o, .pin_status_o, .pin_irq_o, .mic_data_o, .bclk_in_o, .bclk_from_pin_o);

// ===== verif/mpc_pin_partner.sv
`timescale 1ns/1ps
// External parts on the five pins plus pad resistors
module mpc_pin_partner (
	input wire logic         clk_i,
	input mpc_pkg::mpc_pad_t pad_i,
	input wire logic [4:0]   ext_en_i,
	input wire logic [4:0]   ext_val_i,
	output logic [4:0]       pin_o
);
	import mpc_pkg::*;
	logic [4:0] float_q = 5'h00;
	// Undriven pins wander, so no settled value fakes a level
	always @(posedge clk_i) float_q <= ~float_q;
	// Pad drive wins, then the external part, then one resistor
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (pad_i.oe[i]) pin_o[i] = pad_i.out[i];
			else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
			else if (pad_i.pu[i] != pad_i.pd[i]) pin_o[i] = pad_i.pu[i];
			else pin_o[i] = float_q[i];
		end
	end
endmodule

// ===== verif/mpc_top_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the pin control block
module mpc_top_tb;
	import mpc_pkg::*;
	logic         clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic         mclk_i = 1'b0;
	mpc_bus_req_t bus_i = '0;
	mpc_src_t     src_i = '0;
	logic [4:0]   ext_en = 5'h00;
	logic [4:0]   ext_val = 5'h00;
	logic [4:0]   pin_in_i;
	logic [15:0]  rdata_o;
	mpc_pad_t     pad_o;
	logic [4:0]   pin_status_o;
	logic [4:0]   pin_irq_o;
	logic         mic_data_o;
	logic         bclk_in_o;
	logic         bclk_from_pin_o;
	int           bad_count = 0;
	int           samples_checked = 0;
	int           pulses = 0;
	logic [15:0]  dflt [6] = '{16'h00a8, 16'h00a8, 16'h00a8, 16'h02a8, 16'h01a8, 16'h0000};
	logic [17:0]  gpo [6] = '{18'h00043, 18'h00002, 18'h00140, 18'h00102, 18'h00240, 18'h00400};
	logic [5:0]   fns [4] = '{6'h02, 6'h04, 6'h05, 6'h06};

	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;
	// Master clock stand-in and edge pulse counter for pin 2
	always @(posedge clk_i) begin
		mclk_i <= ~mclk_i;
		if (pin_irq_o[1]) pulses <= pulses + 1;
	end

	mpc_top i_mpc_top (.clk_i, .rst_i, .bus_i, .rdata_o, .pin_in_i, .src_i, .mclk_i, .pad_o, .pin_status_o,
		.pin_irq_o, .mic_data_o, .bclk_in_o, .bclk_from_pin_o);
	mpc_pin_partner i_mpc_pin_partner (.clk_i, .pad_i(pad_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
		.pin_o(pin_in_i));

	task cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Writes settle three cycles so pads are stable when looked at
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i) bus_i <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i) bus_i <= '0;
		cyc(3);
	endtask
	task rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk_i) bus_i <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk_i) bus_i <= '0;
		#1 chk(rdata_o, e);
	endtask
	task drive(input int i, input logic v);
		@(posedge clk_i);
		ext_en[i] <= 1'b1;
		ext_val[i] <= v;
	endtask
	task report_and_stop;
		if (bad_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog well past the longest debounce wait
	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		report_and_stop;
	end

	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		cyc(4);
		chk({1'b0, pad_o.oe, pad_o.pu, pad_o.pd}, 16'h000f);
		for (int i = 0; i < 6; i++) rd(8'h74 + i[7:0], dflt[i]);
		wr(8'h75, 16'hffff);
		wr(8'h79, 16'hffff);
		rd(8'h75, 16'h3fff);
		rd(8'h79, 16'h0000);
		// Output level, drive type, direction and bit clock code on pin 1
		foreach (gpo[i]) begin
			wr(8'h74, gpo[i][17:2]);
			chk({pad_o.oe[0], pad_o.out[0] & pad_o.oe[0]}, gpo[i][1:0]);
		end
		// Internal sources routed out through pin 1
		foreach (fns[i]) begin
			wr(8'h74, {2'b00, fns[i], 8'h00});
			@(posedge clk_i) src_i <= 6'h3c;
			cyc(3);
			chk({pad_o.oe[0], pad_o.out[0]}, 2'b11);
			@(posedge clk_i) src_i <= '0;
			cyc(3);
			chk({pad_o.oe[0], pad_o.out[0]}, 2'b10);
		end
		wr(8'h74, 16'h008c);
		chk({pad_o.pu[0], pad_o.pd[0]}, 2'b00);
		wr(8'h74, 16'h0084);
		chk({pad_o.pu[0], pad_o.pd[0]}, 2'b10);
		// Pin 2 input polarity, level then edge interrupts
		wr(8'h75, 16'h03a0);
		drive(1, 1'b1);
		cyc(8);
		chk({pin_status_o[1], pin_irq_o[1]}, 2'b11);
		wr(8'h75, 16'h0380);
		chk({pin_status_o[1], pin_irq_o[1]}, 2'b00);
		wr(8'h75, 16'h03a2);
		pulses = 0;
		drive(1, 1'b0);
		cyc(8);
		drive(1, 1'b1);
		cyc(8);
		chk(pulses[15:0], 16'h0002);
		wr(8'h75, 16'h0680);
		chk(mic_data_o, 1'b1);
		// Debounced pin 3 ignores a short high, takes a long one
		wr(8'h76, 16'h03a1);
		drive(2, 1'b1);
		cyc(DEBOUNCE_CYC / 2);
		chk(pin_status_o[2], 1'b0);
		drive(2, 1'b0);
		cyc(DEBOUNCE_CYC);
		chk(pin_status_o[2], 1'b0);
		drive(2, 1'b1);
		cyc(DEBOUNCE_CYC + 8);
		chk(pin_status_o[2], 1'b1);
		// Pin 5 bit clock path owns the pad, then master clock fallback
		drive(4, 1'b1);
		src_i <= 6'h03;
		wr(8'h78, 16'h0104);
		chk({bclk_from_pin_o, bclk_in_o, pad_o.pu[4], pad_o.oe[4], pad_o.out[4]}, 5'b11011);
		wr(8'h78, 16'h0000);
		chk({bclk_from_pin_o, bclk_in_o}, {1'b0, ~mclk_i});
		// Reset again in mid-run brings back the bit clock default
		@(posedge clk_i) rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		cyc(1);
		rd(8'h78, 16'h01a8);
		chk(bclk_from_pin_o, 1'b1);
		report_and_stop;
	end
endmodule
